// ---- ubs_pkg.sv ----
// package: constants and types for the usb buffer count and suspend block
// How it works
// - each endpoint buffer keeps a byte count of room left for host data.
// - every error-free bulk packet, in or out, reduces that byte count.
// - bus idle for more than 3 ms moves the interface into l2 suspend.
// - in suspend, host bus activity or a software wake request resumes.
// - remote wake-up is optional; it is provided behind an enable.
package ubs_pkg;
  localparam int NUM_EP = 4;
  localparam int EP_W = 2;
  localparam int CNT_W = 11;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = EP_W + CNT_W + 1;
  localparam logic [CNT_W-1:0] COUNT_RESET = 11'h000;
  localparam int CLK_MHZ = 100;
  localparam int IDLE_MS = 3;
  // strictly longer than 3 ms: one cycle past the figure
  localparam int IDLE_CYCLES = IDLE_MS * 1000 * 1000 * CLK_MHZ / 1000 + 1;
  localparam int WAKE_US = 1000;
  localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;
  localparam int TMR_W = 20;
  typedef enum logic [2:0] {
    UBS_ACTIVE = 3'h1,
    UBS_SUSPEND = 3'h2,
    UBS_WAKE = 3'h4
  } ubs_state_t;
endpackage

// ---- ubs_fifo.sv ----
// file: small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ubs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      // registered so the ready seen outside comes straight from a flop
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule

// ---- ubs_top.sv ----
// file: endpoint byte counting and l2 suspend / remote wake control
`timescale 1ns/1ps
module ubs_top #(
  parameter int IDLE_CYCLES = ubs_pkg::IDLE_CYCLES,
  parameter int WAKE_CYCLES = ubs_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // buffer descriptor load from software
  input wire logic load_valid,
  input wire logic [ubs_pkg::EP_W-1:0] load_ep,
  input wire logic [ubs_pkg::CNT_W-1:0] load_count,
  // packet completion from the protocol engine
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [ubs_pkg::EP_W-1:0] pkt_ep,
  input wire logic [ubs_pkg::CNT_W-1:0] pkt_bytes,
  input wire logic pkt_bulk,
  input wire logic pkt_error,
  // byte count readback
  input wire logic [ubs_pkg::EP_W-1:0] rd_ep,
  output logic [ubs_pkg::CNT_W-1:0] rd_count,
  // bus activity and wake-up
  input wire logic bus_activity,
  input wire logic wake_enable,
  input wire logic wake_request,
  output logic suspended,
  output logic resume_drive
);
  logic act_s1;
  logic act_s2;
  logic [ubs_pkg::CNT_W-1:0] byte_count [ubs_pkg::NUM_EP];
  logic [ubs_pkg::CNT_W-1:0] next_count [ubs_pkg::NUM_EP];
  logic q_valid;
  logic [ubs_pkg::FIFO_W-1:0] q_data;
  logic [ubs_pkg::TMR_W-1:0] timer;
  ubs_pkg::ubs_state_t state;
  ubs_pkg::ubs_state_t next_state;

  // bus activity comes from the line receiver, outside this clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      act_s1 <= bus_activity;
      act_s2 <= act_s1;
    end
  end

  // failed and non-bulk packets are dropped here so the fifo only holds work
  wire pkt_keep = pkt_bulk && !pkt_error;
  ubs_fifo #(
    .WIDTH(ubs_pkg::FIFO_W),
    .DEPTH(ubs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(pkt_valid && pkt_keep),
    .in_ready(pkt_ready),
    .in_data({1'b1, pkt_ep, pkt_bytes}),
    .out_valid(q_valid),
    .out_ready(!load_valid),
    .out_data(q_data)
  );
  // a software load takes the count port; draining waits for as long as load_valid is high
  wire q_take = q_valid && !load_valid;
  wire q_mark = q_data[ubs_pkg::FIFO_W-1];
  wire [ubs_pkg::EP_W-1:0] q_ep = q_data[ubs_pkg::CNT_W +: ubs_pkg::EP_W];
  wire [ubs_pkg::CNT_W-1:0] q_bytes = q_data[ubs_pkg::CNT_W-1:0];

  genvar i;
  generate
    for (i = 0; i < ubs_pkg::NUM_EP; i++) begin : g_ep
      wire hit_load = load_valid && (load_ep == ubs_pkg::EP_W'(i));
      wire hit_pkt = q_take && q_mark && (q_ep == ubs_pkg::EP_W'(i));
      // subtract payload bytes, saturating at zero
      wire [ubs_pkg::CNT_W-1:0] dec = (q_bytes > byte_count[i]) ? '0 : byte_count[i] - q_bytes;
      assign next_count[i] = hit_load ? load_count : (hit_pkt ? dec : byte_count[i]);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) byte_count[i] <= ubs_pkg::COUNT_RESET;
        else byte_count[i] <= next_count[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rd_count <= ubs_pkg::COUNT_RESET;
    else rd_count <= byte_count[rd_ep];
  end

  wire idle_done = (timer >= ubs_pkg::TMR_W'(IDLE_CYCLES - 1));
  wire wake_done = (timer >= ubs_pkg::TMR_W'(WAKE_CYCLES - 1));
  always_comb begin
    next_state = state;
    case (state)
      ubs_pkg::UBS_ACTIVE: begin
        if (!act_s2 && idle_done) next_state = ubs_pkg::UBS_SUSPEND;
      end
      ubs_pkg::UBS_SUSPEND: begin
        // host traffic, or a wake request while wake_enable is high, resumes
        if (act_s2) next_state = ubs_pkg::UBS_ACTIVE;
        else if (wake_request && wake_enable) next_state = ubs_pkg::UBS_WAKE;
      end
      ubs_pkg::UBS_WAKE: begin
        if (wake_done) next_state = ubs_pkg::UBS_ACTIVE;
      end
      default: next_state = ubs_pkg::UBS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ubs_pkg::UBS_ACTIVE;
      timer <= '0;
    end else begin
      state <= next_state;
      // host traffic during remote wake must not stretch the wake pulse
      if (next_state != state || (act_s2 && state != ubs_pkg::UBS_WAKE)) timer <= '0;
      else if (!(idle_done && wake_done)) timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      suspended <= 1'b0;
      resume_drive <= 1'b0;
    end else begin
      suspended <= (next_state == ubs_pkg::UBS_SUSPEND);
      resume_drive <= (next_state == ubs_pkg::UBS_WAKE);
    end
  end
endmodule

// ---- ubs_host_model.sv ----
// host-side model: drives the bus activity level
`timescale 1ns/1ps
module ubs_host_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic talk,
  // bus line
  output logic bus_activity
);
  logic talk_q = 1'b1;
  initial bus_activity = 1'b1;
  // talk is taken on the rising edge so the falling-edge update never races the bench
  always @(posedge clk) talk_q <= talk;
  // host traffic wakes a suspended device
  always @(negedge clk) bus_activity <= talk_q;
endmodule

// ---- ubs_top_properties.sv ----
// checker: port-level properties of ubs_top
`timescale 1ns/1ps
module ubs_top_properties #(
  parameter int IDLE_CYCLES = 20,
  parameter int WAKE_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic load_valid,
  input wire logic [1:0] load_ep,
  input wire logic [10:0] load_count,
  input wire logic pkt_valid,
  input wire logic [1:0] rd_ep,
  input wire logic [10:0] rd_count,
  input wire logic bus_activity,
  input wire logic wake_enable,
  input wire logic wake_request,
  input wire logic suspended,
  input wire logic resume_drive
);
  int idle_n;
  int wake_n;
  // wake length is counted here: the real figure is far beyond a delay range
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_n <= 0;
      wake_n <= 0;
    end else begin
      idle_n <= bus_activity ? 0 : idle_n + 1;
      wake_n <= resume_drive ? wake_n + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_load_back: assert property (
    load_valid && !pkt_valid && rd_ep == load_ep ##1 $stable(rd_ep) |-> ##1 rd_count == $past(load_count, 2))
    else $error("load readback wrong");
  a_idle_early: assert property (
    $rose(suspended) |-> $past(idle_n) >= IDLE_CYCLES) else $error("suspend too early");
  a_host_resume: assert property (
    suspended && bus_activity && !resume_drive |-> ##[1:4] !suspended) else $error("no resume on traffic");
  a_wake_start: assert property (
    suspended && wake_request && wake_enable && !$past(bus_activity, 2) |=> resume_drive && !suspended)
    else $error("wake not started");
  a_wake_gate: assert property (
    $rose(resume_drive) |-> $past(suspended) && $past(wake_enable)) else $error("wake without enable");
  a_wake_len: assert property (
    $fell(resume_drive) |-> wake_n == WAKE_CYCLES) else $error("wake length wrong");
  a_wake_bound: assert property (
    wake_n <= WAKE_CYCLES) else $error("wake pulse too long");
  c_suspend: cover property ($rose(suspended));
  c_wake: cover property ($rose(resume_drive));
  c_load: cover property (load_valid && !pkt_valid);
endmodule
bind ubs_top ubs_top_properties #(.IDLE_CYCLES(IDLE_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_props (.clk, .rstn,
  .load_valid, .load_ep, .load_count, .pkt_valid, .rd_ep, .rd_count, .bus_activity, .wake_enable,
  .wake_request, .suspended, .resume_drive);

// ---- usb_hs_device_buffer_suspend_tb_top.sv ----
// testbench: byte counting, fifo refusal, suspend and wake
`timescale 1ns/1ps
module usb_hs_device_buffer_suspend_tb_top;
  localparam int IDLE = 20;
  localparam int WK = 10;
  logic clk, rstn, load_valid, pkt_valid, pkt_ready, pkt_bulk, pkt_error, talk;
  logic bus_activity, wake_enable, wake_request, suspended, resume_drive;
  logic [1:0] load_ep, pkt_ep, rd_ep;
  logic [10:0] load_count, pkt_bytes, rd_count;
  int n_errors = 0, tests_run = 0, cyc = 0;
  ubs_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WK)) dut (.clk, .rstn, .load_valid, .load_ep, .load_count,
    .pkt_valid, .pkt_ready, .pkt_ep, .pkt_bytes, .pkt_bulk, .pkt_error, .rd_ep, .rd_count, .bus_activity,
    .wake_enable, .wake_request, .suspended, .resume_drive);
  ubs_host_model host (.clk, .talk, .bus_activity);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [10:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [1:0] ep, input logic [10:0] exp);
    rd_ep = ep;
    repeat (2) @(negedge clk);
    check("count", exp, rd_count);
  endtask
  task automatic send(input logic [1:0] ep, input logic [10:0] n, input logic bulk, err);
    {pkt_valid, pkt_ep, pkt_bytes, pkt_bulk, pkt_error} = {1'b1, ep, n, bulk, err};
    while (pkt_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic t_count();
    for (int e = 0; e < 4; e++) begin
      {load_valid, load_ep, load_count} = {1'b1, 2'(e), 11'h200};
      @(negedge clk);
    end
    load_valid = 0;
    send(2'h1, 11'h040, 1, 0);
    send(2'h1, 11'h00D, 1, 0);
    send(2'h2, 11'h040, 0, 0);
    send(2'h3, 11'h040, 1, 1);
    send(2'h0, 11'h010, 1, 0);
    pkt_valid = 0;
    repeat (4) @(negedge clk);
    rd(2'h1, 11'h1B3);
    check("received", 11'h04D, 11'h200 - rd_count);
    rd(2'h2, 11'h200);
    rd(2'h3, 11'h200);
  endtask
  task automatic t_fill();
    {load_valid, load_ep} = {1'b1, 2'h0};
    for (int i = 0; i < 4; i++) send(2'h1, 11'h001, 1, 0);
    check("ready full", 11'h000, 11'(pkt_ready));
    repeat (2) @(negedge clk);
    {load_valid, pkt_valid} = 2'b00;
    repeat (8) @(negedge clk);
    check("ready free", 11'h001, 11'(pkt_ready));
    rd(2'h1, 11'h1AF);
  endtask
  task automatic t_suspend();
    talk = 0;
    repeat (IDLE + 2) @(negedge clk);
    check("early", 11'h000, 11'(suspended));
    repeat (2) @(negedge clk);
    check("suspend", 11'h001, 11'(suspended));
    talk = 1;
    repeat (5) @(negedge clk);
    check("host resume", 11'h000, 11'(suspended));
  endtask
  task automatic t_wake();
    talk = 0;
    repeat (IDLE + 6) @(negedge clk);
    wake_request = 1;
    repeat (3) @(negedge clk);
    check("gated", 11'h001, {9'h0, resume_drive, suspended});
    wake_enable = 1;
    @(negedge clk);
    check("wake", 11'h002, {9'h0, resume_drive, suspended});
    wake_request = 0;
    repeat (WK - 1) @(negedge clk);
    check("wake hold", 11'h002, {9'h0, resume_drive, suspended});
    @(negedge clk);
    check("wake end", 11'h000, {9'h0, resume_drive, suspended});
    talk = 1;
  endtask
  initial begin
    {rstn, load_valid, pkt_valid, pkt_bulk, pkt_error, wake_enable, wake_request, talk} = 8'h01;
    {load_ep, pkt_ep, rd_ep, load_count, pkt_bytes} = '0;
    repeat (8) @(negedge clk);
    rstn = 1;
    check("reset", 11'h001, {9'h0, suspended, pkt_ready});
    rd(2'h0, 11'h000);
    t_count();
    t_fill();
    t_suspend();
    t_wake();
    print_verdict();
  end
endmodule
